// file: core/smdtp_port.sv
// Drive-side tag bus port: select, tag decode, positioner status.
// Assumes raw pins from line receivers and an Avalon-MM master.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module smdtp_port import smdtp_pkg::*; (
  input wire logic clk_i, // Clock 125 MHz
  input wire logic rst_i, // Sync reset
  input wire logic [BUS_W-1:0] bus_i, // Bus bits 0..10
  input wire logic tag_cyl_i, // Cylinder address tag
  input wire logic tag_head_i, // Head select tag
  input wire logic tag_ctrl_i, // Control select tag
  input wire logic unit_tag_i, // Unit select tag
  input wire logic [UADDR_W-1:0] unit_addr_i, // Unit address lines
  input wire logic [SW_W-1:0] addr_switch_i, // Address switch pack
  input wire logic eleven_bit_bus_jumper_pos_i, // Bit 10 enabled
  input wire logic index_i, // Index mark from servo
  input wire logic sector_i, // Sector mark from servo
  input wire logic write_protect_i, // Write protect switch
  input wire logic unit_ready_i, // Spindle at speed
  input wire logic [AV_AW-1:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read strobe
  input wire logic avs_write_i, // Write strobe
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Wait request
  output logic unit_selected_o, // Unit selected
  output logic seek_end_o, // Seek end
  output logic write_enable_o, // Write driver enable
  output logic read_enable_o, // Read data drive enable
  output logic read_sync_o, // Read sync start pulse
  output logic [CYL_W-1:0] target_cyl_o, // Target cylinder
  output logic [HEAD_W-1:0] head_o, // Selected head
  output logic seek_start_o, // Seek start pulse
  output logic rtz_start_o, // Return to zero start pulse
  output logic st_index_o, // Status: index
  output logic st_sector_o, // Status: sector
  output logic st_fault_o, // Status: fault
  output logic st_seek_error_o, // Status: seek error
  output logic st_on_cyl_o, // Status: on cylinder
  output logic st_ready_o, // Status: unit ready
  output logic st_write_prot_o // Status: write protected
);
  ////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int unsigned SW = BUS_W + 4 + UADDR_W + 5;
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  assign raw = {bus_i, tag_cyl_i, tag_head_i, tag_ctrl_i, unit_tag_i, unit_addr_i,
                index_i, sector_i, write_protect_i, unit_ready_i, eleven_bit_bus_jumper_pos_i};
  smdtp_sync #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(raw),
    .q_o(syn)
  );
  logic [BUS_W-1:0] bus_s;
  logic tcyl_s, thead_s, tctrl_s, utag_s;
  logic [UADDR_W-1:0] uaddr_s;
  logic idx_s, sec_s, wp_s, rdy_s, jmp_s;
  assign {bus_s, tcyl_s, thead_s, tctrl_s, utag_s, uaddr_s, idx_s, sec_s, wp_s, rdy_s, jmp_s} = syn;

  ////////////////////////////////////////////////////////////
  // Software control and positioner model
  logic [CTRL_W-1:0] ctrl_reg;
  smdtp_pos_e pos_reg;
  logic fault_reg;
  logic seek_err_reg;
  logic on_cyl_reg;
  logic [CYL_W-1:0] cur_cyl_reg;

  ////////////////////////////////////////////////////////////
  // Unit select
  logic utag_d_reg;
  logic sel_reg;
  logic addr_match;
  assign addr_match = (uaddr_s == addr_switch_i[SW_ADDR_LSB +: UADDR_W]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      utag_d_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      utag_d_reg <= utag_s;
      if (!utag_s) begin
        sel_reg <= 1'b0;
      end else if (!utag_d_reg && addr_match) begin
        sel_reg <= 1'b1;
      end
    end
  end
  assign unit_selected_o = sel_reg;

  ////////////////////////////////////////////////////////////
  // Tag decode
  logic tcyl_d_reg, thead_d_reg;
  logic [BUS_W-1:0] bus_eff;
  logic cyl_take, head_take, rtz_fire, fclr_fire;
  logic read_gate, read_d_reg;
  assign bus_eff = jmp_s ? bus_s : {1'b0, bus_s[BIT_OPT-1:0]};
  assign cyl_take = sel_reg && tcyl_s && !tcyl_d_reg;
  assign head_take = sel_reg && thead_s && !thead_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcyl_d_reg <= 1'b0;
      thead_d_reg <= 1'b0;
      target_cyl_o <= '0;
      head_o <= '0;
      seek_start_o <= 1'b0;
    end else begin
      tcyl_d_reg <= tcyl_s;
      thead_d_reg <= thead_s;
      seek_start_o <= cyl_take;
      if (cyl_take) begin
        target_cyl_o <= bus_eff;
      end
      if (rtz_fire) begin
        head_o <= '0;
      end else if (head_take) begin
        head_o <= bus_eff[HEAD_W-1:0];
      end
    end
  end
  logic ctl_on;
  assign ctl_on = sel_reg && tctrl_s;
  smdtp_pulse #(.MIN_CYC(PULSE_MIN_CYC)) u_fclr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lvl_i(ctl_on && bus_eff[CB_FCLR]),
    .fire_o(fclr_fire)
  );
  smdtp_pulse #(.MIN_CYC(PULSE_MIN_CYC)) u_rtz (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lvl_i(ctl_on && bus_eff[CB_RTZ]),
    .fire_o(rtz_fire)
  );
  assign read_gate = ctl_on && bus_eff[CB_READ];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_enable_o <= 1'b0;
      read_enable_o <= 1'b0;
      read_sync_o <= 1'b0;
      read_d_reg <= 1'b0;
      rtz_start_o <= 1'b0;
    end else begin
      write_enable_o <= ctl_on && bus_eff[CB_WRITE] && !fault_reg && !ctrl_reg[CTRL_FAULT_IN];
      read_enable_o <= read_gate;
      read_d_reg <= read_gate;
      read_sync_o <= read_gate && !read_d_reg;
      rtz_start_o <= rtz_fire;
    end
  end

  ////////////////////////////////////////////////////////////
  // Positioner status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= SMDTP_IDLE;
      on_cyl_reg <= 1'b1;
      cur_cyl_reg <= '0;
    end else begin
      case (pos_reg)
        SMDTP_IDLE: begin
          if (rtz_fire) begin
            pos_reg <= SMDTP_RTZ;
            on_cyl_reg <= 1'b0;
          end else if (cyl_take) begin
            pos_reg <= SMDTP_SEEK;
            on_cyl_reg <= 1'b0;
          end
        end
        SMDTP_SEEK: begin
          if (rtz_fire) begin
            pos_reg <= SMDTP_RTZ;
          end else if (ctrl_reg[CTRL_SETTLED]) begin
            pos_reg <= SMDTP_IDLE;
            on_cyl_reg <= 1'b1;
            cur_cyl_reg <= target_cyl_o;
          end
        end
        SMDTP_RTZ: begin
          if (ctrl_reg[CTRL_SETTLED]) begin
            pos_reg <= SMDTP_IDLE;
            on_cyl_reg <= 1'b1;
            cur_cyl_reg <= '0;
          end
        end
        default: begin
          pos_reg <= SMDTP_IDLE;
        end
      endcase
    end
  end
  // Set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
      seek_err_reg <= 1'b0;
    end else begin
      if (ctrl_reg[CTRL_FAULT_IN]) begin
        fault_reg <= 1'b1;
      end else if (fclr_fire || rtz_fire) begin
        fault_reg <= 1'b0;
      end
      if (ctrl_reg[CTRL_SEEKERR_IN]) begin
        seek_err_reg <= 1'b1;
      end else if (rtz_fire) begin
        seek_err_reg <= 1'b0;
      end
    end
  end
  assign seek_end_o = on_cyl_reg || seek_err_reg;
  // Status gated by selection
  assign st_index_o = sel_reg && idx_s;
  assign st_sector_o = sel_reg && sec_s;
  assign st_fault_o = sel_reg && fault_reg;
  assign st_seek_error_o = sel_reg && seek_err_reg;
  assign st_on_cyl_o = sel_reg && on_cyl_reg;
  assign st_ready_o = sel_reg && rdy_s && !fault_reg;
  assign st_write_prot_o = sel_reg && wp_s;

  ////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access
  logic ack_reg;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      ctrl_reg <= CTRL_RST;
      avs_readdata_o <= '0;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
      // Write lands on the edge that completes the transfer
      if (avs_write_i && ack_reg && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
        ctrl_reg <= avs_writedata_i[CTRL_W-1:0];
      end else begin
        ctrl_reg[CTRL_SETTLED] <= 1'b0;
      end
      if (avs_read_i && !ack_reg) begin
        if (avs_address_i == OFS_STATUS) begin
          avs_readdata_o <= {24'h000000, pos_reg, sel_reg, fault_reg, seek_err_reg, on_cyl_reg, seek_end_o};
        end else if (avs_address_i == OFS_CYL) begin
          avs_readdata_o <= {5'h00, cur_cyl_reg, 5'h00, target_cyl_o};
        end else if (avs_address_i == OFS_CTRL) begin
          avs_readdata_o <= {29'h00000000, ctrl_reg};
        end else if (avs_address_i == OFS_POS) begin
          avs_readdata_o <= {28'h0000000, read_enable_o, write_enable_o, head_o[1:0]};
        end else begin
          avs_readdata_o <= 32'h00000000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  sequence tag_rise_s;
    utag_s && !utag_d_reg && addr_match;
  endsequence
  unit_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tag_rise_s |=> sel_reg) else $error("unit not selected after tag");
  select_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !utag_s |=> !sel_reg) else $error("selected without tag");
  seek_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    seek_end_o == (on_cyl_reg || seek_err_reg)) else $error("seek end mismatch");
  write_inhibit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_reg |=> !write_enable_o) else $error("write while faulted");
  cyl_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyl_take |=> target_cyl_o == $past(bus_eff) && seek_start_o) else $error("cylinder not captured");
  head_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    head_take && !rtz_fire |=> head_o == $past(bus_eff[HEAD_W-1:0])) else $error("head not taken");
  read_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    read_gate && !read_d_reg |=> read_sync_o && read_enable_o) else $error("read sync missing");
  rtz_motion_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rtz_fire && pos_reg == SMDTP_IDLE |=> !on_cyl_reg && head_o == '0 && pos_reg == SMDTP_RTZ)
    else $error("rtz not started");
  fault_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fclr_fire && !ctrl_reg[CTRL_FAULT_IN] |=> !fault_reg) else $error("fault not cleared");
endmodule

// file: core/smdtp_pkg.sv
// Constants, states and register map of the tag bus drive port.
// Assumes a 125 MHz clock; used by every core file.
package smdtp_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PULSE_MIN_NS = 250;
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SEL_MAX_NS = 200;
  localparam int unsigned SEL_MAX_CYC = (SEL_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned BUS_W = 11;
  localparam int unsigned CYL_W = 11;
  localparam int unsigned HEAD_W = 3;
  localparam int unsigned UADDR_W = 4;
  localparam int unsigned SW_W = 8;
  localparam int unsigned SW_ADDR_LSB = 0;
  localparam int unsigned BIT_OPT = 10;
  localparam int unsigned CB_WRITE = 0;
  localparam int unsigned CB_READ = 1;
  localparam int unsigned CB_FCLR = 4;
  localparam int unsigned CB_RTZ = 6;
  localparam int unsigned CNT_W = 8;
  // Register bus
  localparam int unsigned AV_AW = 4;
  localparam logic [AV_AW-1:0] OFS_STATUS = 4'h0;
  localparam logic [AV_AW-1:0] OFS_CYL = 4'h4;
  localparam logic [AV_AW-1:0] OFS_CTRL = 4'h8;
  localparam logic [AV_AW-1:0] OFS_POS = 4'hC;
  localparam int unsigned CTRL_FAULT_IN = 0;
  localparam int unsigned CTRL_SEEKERR_IN = 1;
  localparam int unsigned CTRL_SETTLED = 2;
  localparam int unsigned CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  typedef enum logic [2:0] {
    SMDTP_IDLE = 3'b001,
    SMDTP_SEEK = 3'b010,
    SMDTP_RTZ = 3'b100
  } smdtp_pos_e;
endpackage

// file: core/smdtp_sync.sv
// Three-stage pin synchroniser with agree filter.
// Assumes input is asynchronous to clk_i.
`timescale 1ns/1ps
module smdtp_sync import smdtp_pkg::*; #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic [W-1:0] d_i, // Raw pin
  output logic [W-1:0] q_o // Filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Change counts once second and third agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_o[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// file: core/smdtp_pulse.sv
// Minimum-width pulse qualifier: fires once a level is held long enough.
// Assumes a synchronised input.
`timescale 1ns/1ps
module smdtp_pulse import smdtp_pkg::*; #(
  parameter int unsigned MIN_CYC = 1
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic lvl_i, // Level in
  output logic fire_o // One-cycle pulse
);
  logic [CNT_W-1:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !lvl_i) begin
      cnt_reg <= '0;
    end else if (cnt_reg != CNT_W'(MIN_CYC)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  assign fire_o = lvl_i && (cnt_reg == CNT_W'(MIN_CYC - 1));
endmodule

// file: tb/smdtp_host.sv
// Host controller model: drives unit select, tag strobes and bus word.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module smdtp_host import smdtp_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic on_cyl_i, // On cylinder status
  output logic [BUS_W-1:0] bus_o, // Bus bits 0..10
  output logic tag_cyl_o, // Cylinder tag
  output logic tag_head_o, // Head tag
  output logic tag_ctrl_o, // Control tag
  output logic unit_tag_o, // Unit select tag
  output logic [UADDR_W-1:0] unit_addr_o // Unit address lines
);
  localparam int SETUP_CYC = 25;
  localparam int W2R_CYC = 1750;
  int cyc = 0;
  int wg_end = -10000;
  initial begin
    bus_o = 11'h2A5;
    tag_cyl_o = 1'b0;
    tag_head_o = 1'b0;
    tag_ctrl_o = 1'b0;
    unit_tag_o = 1'b0;
    unit_addr_o = 4'hA;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////
  task automatic select(input logic [UADDR_W-1:0] a);
    @(posedge clk_i);
    unit_addr_o <= a;
    repeat (SETUP_CYC) @(posedge clk_i);
    unit_tag_o <= 1'b1;
  endtask
  task automatic deselect();
    @(posedge clk_i);
    unit_tag_o <= 1'b0;
    unit_addr_o <= ~unit_addr_o;
  endtask
  // Kind 0 cylinder, 1 head, 2 control
  task automatic send(input int kind, input logic [BUS_W-1:0] w, input int hold);
    int n;
    n = 0;
    while (kind == 0 && on_cyl_i !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    while (kind == 2 && w[CB_READ] && cyc - wg_end < W2R_CYC) @(posedge clk_i);
    @(posedge clk_i);
    bus_o <= w;
    @(posedge clk_i);
    tag_cyl_o <= (kind == 0);
    tag_head_o <= (kind == 1);
    tag_ctrl_o <= (kind == 2);
    repeat (hold) @(posedge clk_i);
    tag_cyl_o <= 1'b0;
    tag_head_o <= 1'b0;
    tag_ctrl_o <= 1'b0;
    if (kind == 2 && w[CB_WRITE]) wg_end = cyc;
    @(posedge clk_i);
    bus_o <= ~w;
  endtask
endmodule

// file: tb/smd_tag_bus_drive_port_tb.sv
// Self-checking bench of the drive tag bus port.
// Assumes smdtp_host as the controller and a bench Avalon master.
`timescale 1ns/1ps
module smd_tag_bus_drive_port_tb import smdtp_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [BUS_W-1:0] bus_i;
  logic tag_cyl_i, tag_head_i, tag_ctrl_i, unit_tag_i;
  logic [UADDR_W-1:0] unit_addr_i;
  logic [SW_W-1:0] addr_switch_i = 8'h00;
  logic eleven_bit_bus_jumper_pos_i = 1'b0, index_i = 1'b0, sector_i = 1'b0;
  logic write_protect_i = 1'b0, unit_ready_i = 1'b0;
  logic [AV_AW-1:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic avs_waitrequest_o, unit_selected_o, seek_end_o, write_enable_o, read_enable_o;
  logic read_sync_o, seek_start_o, rtz_start_o, we, re;
  logic [CYL_W-1:0] target_cyl_o, exp_cyl;
  logic [HEAD_W-1:0] head_o;
  logic st_index_o, st_sector_o, st_fault_o, st_seek_error_o, st_on_cyl_o, st_ready_o, st_write_prot_o;
  logic [15:0] seed = 16'h0055;
  logic [3:0] my_addr;
  logic [BUS_W-1:0] w;
  int bad_count = 0;
  int tests_run = 0;
  int n_seek = 0, n_sync = 0, n_rtz = 0, p;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (seek_start_o === 1'b1) n_seek++;
    if (read_sync_o === 1'b1) n_sync++;
    if (rtz_start_o === 1'b1) n_rtz++;
  end
  smdtp_port dut (.clk_i, .rst_i, .bus_i, .tag_cyl_i, .tag_head_i, .tag_ctrl_i, .unit_tag_i, .unit_addr_i,
    .addr_switch_i, .eleven_bit_bus_jumper_pos_i, .index_i, .sector_i, .write_protect_i, .unit_ready_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .unit_selected_o, .seek_end_o, .write_enable_o, .read_enable_o, .read_sync_o,
    .target_cyl_o, .head_o, .seek_start_o, .rtz_start_o, .st_index_o, .st_sector_o, .st_fault_o,
    .st_seek_error_o, .st_on_cyl_o, .st_ready_o, .st_write_prot_o);
  smdtp_host host (.clk_i(clk_i), .on_cyl_i(st_on_cyl_o), .bus_o(bus_i), .tag_cyl_o(tag_cyl_i),
    .tag_head_o(tag_head_i), .tag_ctrl_o(tag_ctrl_i), .unit_tag_o(unit_tag_i), .unit_addr_o(unit_addr_i));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      $display("[ERR] %0t %s", $time, m);
      bad_count++;
    end
  endtask
  task automatic av(input logic wr, input logic [AV_AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20) begin
      chk(1'b0, "bus timeout");
      results();
    end
  endtask
  // Control word held 40 cycles; enables sampled mid-hold
  task automatic ctl(input logic [BUS_W-1:0] cw);
    int n;
    fork
      host.send(2, cw, 40);
      begin
        for (n = 0; n < 2000 && tag_ctrl_i !== 1'b1; n++) @(posedge clk_i);
        repeat (20) @(posedge clk_i);
        we = write_enable_o;
        re = read_enable_o;
      end
    join
    repeat (8) @(posedge clk_i);
  endtask
  task automatic settle();
    av(1'b1, OFS_CTRL, 32'(1 << CTRL_SETTLED));
    repeat (8) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(seek_end_o === 1'b1 && unit_selected_o === 1'b0, "reset outputs");
    seed = lf(seed);
    my_addr = seed[3:0];
    for (int i = 0; i < 16; i++) begin
      seed = lf(seed);
      addr_switch_i <= {seed[7:4], my_addr};
      host.select(i[3:0]);
      for (p = 0; p < 26 && unit_selected_o !== 1'b1; p++) @(posedge clk_i);
      chk(unit_selected_o === (i[3:0] == my_addr), "unit select compare");
      host.deselect();
      repeat (8) @(posedge clk_i);
    end
    host.select(my_addr);
    for (p = 0; p < 26 && unit_selected_o !== 1'b1; p++) @(posedge clk_i);
    if (unit_selected_o !== 1'b1) begin
      chk(1'b0, "select lost");
      results();
    end
    {index_i, sector_i, write_protect_i, unit_ready_i} <= seed[11:8];
    repeat (8) @(posedge clk_i);
    chk({st_index_o, st_sector_o, st_write_prot_o, st_ready_o} === {index_i, sector_i, write_protect_i,
      unit_ready_i}, "status lines");
    write_protect_i <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      seed = lf(seed);
      w = (j == 3) ? 11'h7FF : seed[10:0];
      eleven_bit_bus_jumper_pos_i <= j[0];
      p = n_seek;
      host.send(0, w, 8);
      repeat (8) @(posedge clk_i);
      exp_cyl = j[0] ? w : {1'b0, w[9:0]};
      chk(target_cyl_o === exp_cyl && n_seek == p + 1, "cylinder capture");
      av(1'b0, OFS_CYL, 32'h0);
      chk(rd[10:0] === exp_cyl, "cylinder register");
      settle();
      chk(st_on_cyl_o === 1'b1 && seek_end_o === 1'b1, "seek end on cylinder");
    end
    av(1'b1, OFS_CYL, 32'h0);
    av(1'b0, OFS_CYL, 32'h0);
    chk(rd[10:0] === exp_cyl, "read-only cylinder");
    av(1'b0, 4'h1, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    for (int j = 0; j < 3; j++) begin
      seed = lf(seed);
      host.send(1, seed[10:0] | 11'h7F8, 8);
      repeat (8) @(posedge clk_i);
      chk(head_o === seed[2:0], "head select");
    end
    ctl(11'(1 << CB_WRITE));
    chk(we === 1'b1 && write_enable_o === 1'b0, "write gate");
    p = n_sync;
    ctl(11'(1 << CB_READ));
    chk(re === 1'b1 && read_enable_o === 1'b0 && n_sync == p + 1, "read gate");
    p = n_sync + n_rtz;
    ctl(11'h3AC);
    chk(we === 1'b0 && re === 1'b0 && n_sync + n_rtz == p && st_fault_o === 1'b0, "ignored bits");
    av(1'b1, OFS_CTRL, 32'(1 << CTRL_FAULT_IN));
    ctl(11'(1 << CB_WRITE));
    chk(we === 1'b0 && st_fault_o === 1'b1, "fault inhibits write");
    ctl(11'(1 << CB_FCLR));
    chk(st_fault_o === 1'b1, "fault persists");
    av(1'b1, OFS_CTRL, 32'h0);
    ctl(11'(1 << CB_FCLR));
    chk(st_fault_o === 1'b0, "fault clear");
    host.send(1, 11'h005, 8);
    host.send(0, 11'h123, 8);
    repeat (8) @(posedge clk_i);
    chk(seek_end_o === 1'b0, "seek end while seeking");
    av(1'b1, OFS_CTRL, 32'(1 << CTRL_SEEKERR_IN));
    repeat (4) @(posedge clk_i);
    chk(st_seek_error_o === 1'b1 && seek_end_o === 1'b1, "seek end on error");
    av(1'b1, OFS_CTRL, 32'h0);
    p = n_rtz;
    ctl(11'(1 << CB_RTZ));
    chk(head_o === 3'h0 && st_seek_error_o === 1'b0 && n_rtz == p + 1, "return to zero");
    chk(st_on_cyl_o === 1'b0, "moving off cylinder");
    settle();
    chk(st_on_cyl_o === 1'b1, "settled at zero");
    av(1'b0, OFS_STATUS, 32'h0);
    chk(rd[4] === 1'b1 && rd[1:0] === 2'h3, "status register");
    host.deselect();
    repeat (8) @(posedge clk_i);
    chk(unit_selected_o === 1'b0 && st_on_cyl_o === 1'b0, "deselect gating");
    p = n_seek;
    host.send(0, 11'h055, 8);
    ctl(11'(1 << CB_WRITE));
    chk(target_cyl_o === 11'h123 && n_seek == p && we === 1'b0, "tags ignored unselected");
    results();
  end
endmodule
